/* design/dma_full_address_channel_control.sv */
`timescale 1ns/10ps
module dma_full_address_channel_control
   import dma_fa_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // system
   input  wire logic        nmi,
   input  wire logic        standby,
   // activation sources
   input  wire logic [3:0]  timerMatch,
   input  wire logic        extReqPin,
   input  wire logic        higherChannelReq,
   // system bus
   output logic             busRequest,
   input  wire logic        busGrant,
   input  wire logic        higherMasterReq,
   output logic             xferStart,
   output logic      [23:0] xferSrc,
   output logic      [23:0] xferDst,
   output logic             xferWord,
   input  wire logic        xferDone,
   // interrupt
   output logic             irq
);
   import dma_fa_pkg::*;

   logic [7:0]  ctrlA_reg, ctrlA_next, ctrlB_reg, ctrlB_next;
   logic        armed_reg, armed_next;
   logic [23:0] dest_reg, dest_next, src_reg, src_next;
   logic [23:0] destInit_reg, destInit_next, srcInit_reg, srcInit_next;
   logic [15:0] count_reg, count_next;
   logic [7:0]  blkCnt_reg, blkCnt_next, blkSize_reg, blkSize_next;
   logic [1:0]  status_reg, status_next, mask_reg, mask_next;
   eng_state_t  state_reg, state_next;
   logic        pend_reg, pend_next, busReq_reg, busReq_next;
   logic        start_reg, start_next, irq_reg, irq_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next, pslverr_reg, pslverr_next;

   logic        apbAccess, wrEn, rdEn, mapped;
   logic        blockMode, fullMode, chanOn, autoReq, burst, edgeEv, levelReq, want;
   logic        xferEnd, blockEnd, lastXfer, pendClr;
   logic [2:0]  act;
   logic [23:0] step;
   logic [1:0]  evSet;

   act_if actBus ();

   req_sync u_sync (
      .clk       (clk),
      .rst       (rst),
      .extReqPin (extReqPin),
      .act       (actBus.drive)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   always_comb begin
      apbAccess = psel & penable & ~pready_reg;
      wrEn      = psel & penable & pready_reg & pwrite;
      rdEn      = psel & penable & pready_reg & ~pwrite;
      mapped    = (paddr == OFF_CTRL_A) | (paddr == OFF_CTRL_B) | (paddr == OFF_DEST) |
                  (paddr == OFF_SRC) | (paddr == OFF_COUNT) | (paddr == OFF_BLOCK) |
                  (paddr == OFF_STATUS) | (paddr == OFF_MASK) | (paddr == OFF_STATE);
      blockMode = ctrlA_reg[A_BLOCK];
      fullMode  = ctrlA_reg[A_FULL_HI] & ctrlA_reg[A_FULL_LO];
      chanOn    = fullMode & ctrlB_reg[B_MTE] & ctrlA_reg[A_TE];
      act       = ctrlB_reg[2:0];
      autoReq   = ~blockMode & ((act == ACT_BURST) | (act == ACT_STEAL));
      burst     = ~blockMode & (act == ACT_BURST);
      if (blockMode & ~act[2])
         edgeEv = chanOn & timerMatch[act[1:0]];
      else
         edgeEv = chanOn & (act == ACT_EXT_FALL) & actBus.extFall;
      levelReq  = chanOn & ~blockMode & (act == ACT_EXT_LOW) & actBus.extLow;
      // a shared internal source waits for the higher channel
      want      = chanOn & (autoReq | levelReq | pend_reg) &
                  ~(blockMode & ~act[2] & higherChannelReq);
      step      = ctrlA_reg[A_SIZE] ? STEP_WORD : STEP_BYTE;
      xferEnd   = (state_reg == ST_XFER) & xferDone;
      blockEnd  = xferEnd & blockMode & (blkCnt_reg <= BLK_ONE);
      lastXfer  = (count_reg <= COUNT_ONE) & (blockMode ? blockEnd : xferEnd);
   end

   // ----------------------------------------
   // transfer engine
   // ----------------------------------------
   always_comb begin
      state_next  = state_reg;
      busReq_next = busReq_reg;
      start_next  = 1'b0;
      pendClr     = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (want) begin
               state_next  = ST_REQ;
               busReq_next = 1'b1;
            end
         end
         ST_REQ: begin
            // suspension keeps counts and addresses untouched
            if (!chanOn) begin
               state_next  = ST_IDLE;
               busReq_next = 1'b0;
            end else if (busGrant) begin
               state_next = ST_XFER;
               start_next = 1'b1;
            end
         end
         ST_XFER: begin
            if (xferDone) begin
               pendClr = ~blockMode | blockEnd;
               if (!lastXfer && chanOn && !higherMasterReq &&
                   (burst || (blockMode && !blockEnd))) begin
                  start_next = 1'b1;
               end else begin
                  state_next  = ST_GAP;
                  busReq_next = 1'b0;
               end
            end
         end
         ST_GAP: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next  = ST_IDLE;
            busReq_next = 1'b0;
         end
      endcase
      // an edge in the clearing cycle is kept
      pend_next = (pend_reg & ~pendClr) | edgeEv;
      if (rst | standby)
         pend_next = 1'b0;
   end

   // ----------------------------------------
   // registers and apb
   // ----------------------------------------
   always_comb begin
      ctrlA_next    = ctrlA_reg;
      ctrlB_next    = ctrlB_reg;
      armed_next    = armed_reg;
      dest_next     = dest_reg;
      src_next      = src_reg;
      destInit_next = destInit_reg;
      srcInit_next  = srcInit_reg;
      count_next    = count_reg;
      blkCnt_next   = blkCnt_reg;
      blkSize_next  = blkSize_reg;
      mask_next     = mask_reg;
      evSet         = EVT_RESET;
      if (xferEnd) begin
         if (ctrlB_reg[B_STEP_EN])
            dest_next = ctrlB_reg[B_DIR] ? dest_reg - step : dest_reg + step;
         if (ctrlA_reg[A_SSTEP])
            src_next = ctrlA_reg[A_SDIR] ? src_reg - step : src_reg + step;
         if (blockMode) begin
            blkCnt_next = blkCnt_reg - BLK_ONE;
            if (blockEnd) begin
               blkCnt_next = blkSize_reg;
               count_next  = count_reg - COUNT_ONE;
               if (ctrlB_reg[B_BLK_SIDE])
                  src_next = srcInit_reg;
               else
                  dest_next = destInit_reg;
            end
         end else begin
            count_next = count_reg - COUNT_ONE;
         end
      end
      if (wrEn) begin
         case (paddr)
            OFF_CTRL_A: ctrlA_next = pwdata[7:0];
            OFF_CTRL_B: begin
               ctrlB_next[6:0]   = pwdata[6:0];
               ctrlB_next[B_MTE] = pwdata[B_MTE] & (armed_reg | ctrlB_reg[B_MTE]);
               armed_next        = 1'b0;
            end
            OFF_DEST: begin
               dest_next     = pwdata[23:0];
               destInit_next = pwdata[23:0];
            end
            OFF_SRC: begin
               src_next     = pwdata[23:0];
               srcInit_next = pwdata[23:0];
            end
            OFF_COUNT: count_next = pwdata[15:0];
            OFF_BLOCK: begin
               blkCnt_next  = pwdata[15:8];
               blkSize_next = pwdata[7:0];
            end
            OFF_MASK: mask_next = pwdata[1:0];
            default: begin
            end
         endcase
      end
      if (rdEn && paddr == OFF_CTRL_B && !ctrlB_reg[B_MTE])
         armed_next = 1'b1;
      if (lastXfer) begin
         ctrlA_next[A_TE] = 1'b0;
         evSet[EV_DONE]   = 1'b1;
      end
      if (nmi) begin
         ctrlB_next[B_MTE] = 1'b0;
         evSet[EV_NMI]     = ctrlB_reg[B_MTE];
      end
      status_next = status_reg;
      if (wrEn && paddr == OFF_STATUS)
         status_next = status_reg & ~pwdata[1:0];
      status_next = status_next | evSet;
      if (standby) begin
         ctrlA_next = CTRL_RESET;
         ctrlB_next = CTRL_RESET;
         armed_next = 1'b0;
      end
      irq_next     = |(status_reg & mask_reg);
      pready_next  = apbAccess;
      pslverr_next = apbAccess & ~mapped;
      prdata_next  = 32'h00000000;
      if (apbAccess) begin
         case (paddr)
            OFF_CTRL_A: prdata_next = {24'h000000, ctrlA_reg};
            OFF_CTRL_B: prdata_next = {24'h000000, ctrlB_reg};
            OFF_DEST:   prdata_next = {8'h00, dest_reg};
            OFF_SRC:    prdata_next = {8'h00, src_reg};
            OFF_COUNT:  prdata_next = {16'h0000, count_reg};
            OFF_BLOCK:  prdata_next = {16'h0000, blkCnt_reg, blkSize_reg};
            OFF_STATUS: prdata_next = {30'h00000000, status_reg};
            OFF_MASK:   prdata_next = {30'h00000000, mask_reg};
            OFF_STATE:  prdata_next = {27'h0000000, state_reg, busReq_reg, pend_reg, chanOn};
            default:    prdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrlA_reg    <= CTRL_RESET;
         ctrlB_reg    <= CTRL_RESET;
         armed_reg    <= 1'b0;
         dest_reg     <= ADDR_RESET;
         src_reg      <= ADDR_RESET;
         destInit_reg <= ADDR_RESET;
         srcInit_reg  <= ADDR_RESET;
         count_reg    <= COUNT_RESET;
         blkCnt_reg   <= BLK_RESET;
         blkSize_reg  <= BLK_RESET;
         status_reg   <= EVT_RESET;
         mask_reg     <= EVT_RESET;
         state_reg    <= ST_IDLE;
         pend_reg     <= 1'b0;
         busReq_reg   <= 1'b0;
         start_reg    <= 1'b0;
         irq_reg      <= 1'b0;
         prdata_reg   <= 32'h00000000;
         pready_reg   <= 1'b0;
         pslverr_reg  <= 1'b0;
      end else begin
         ctrlA_reg    <= ctrlA_next;
         ctrlB_reg    <= ctrlB_next;
         armed_reg    <= armed_next;
         dest_reg     <= dest_next;
         src_reg      <= src_next;
         destInit_reg <= destInit_next;
         srcInit_reg  <= srcInit_next;
         count_reg    <= count_next;
         blkCnt_reg   <= blkCnt_next;
         blkSize_reg  <= blkSize_next;
         status_reg   <= status_next;
         mask_reg     <= mask_next;
         state_reg    <= state_next;
         pend_reg     <= pend_next;
         busReq_reg   <= busReq_next;
         start_reg    <= start_next;
         irq_reg      <= irq_next;
         prdata_reg   <= prdata_next;
         pready_reg   <= pready_next;
         pslverr_reg  <= pslverr_next;
      end
   end

   assign prdata     = prdata_reg;
   assign pready     = pready_reg;
   assign pslverr    = pslverr_reg;
   assign busRequest = busReq_reg;
   assign xferStart  = start_reg;
   assign xferSrc    = src_reg;
   assign xferDst    = dest_reg;
   assign xferWord   = ctrlA_reg[A_SIZE];
   assign irq        = irq_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_STANDBY_CLEAR: assert property (@(posedge clk) disable iff (rst)
      standby |=> ctrlB_reg == 8'h00)
      else $error("standby did not clear control b");
   AST_IDLE_WHEN_OFF: assert property (@(posedge clk) disable iff (rst)
      (state_reg == ST_IDLE && !chanOn) |=> state_reg == ST_IDLE && !busReq_reg)
      else $error("engine left idle while channel disabled");
   AST_NMI_CLEAR: assert property (@(posedge clk) disable iff (rst)
      nmi |=> !ctrlB_reg[B_MTE] ##1 (state_reg != ST_XFER || !start_reg))
      else $error("nmi did not clear master enable");
   AST_SUSPEND_HOLD: assert property (@(posedge clk) disable iff (rst)
      (state_reg == ST_IDLE && !chanOn && !wrEn) |=> $stable(count_reg) && $stable(dest_reg))
      else $error("suspended channel lost its progress");
   AST_ARM_NEEDED: assert property (@(posedge clk) disable iff (rst)
      (wrEn && paddr == OFF_CTRL_B && !armed_reg && !ctrlB_reg[B_MTE]) |=> !ctrlB_reg[B_MTE])
      else $error("master enable set without preceding read");
   AST_RESERVED_RW: assert property (@(posedge clk) disable iff (rst)
      (wrEn && paddr == OFF_CTRL_B && !standby) |=> ctrlB_reg[B_RSVD] == $past(pwdata[B_RSVD]))
      else $error("reserved bit not stored");
   AST_DEST_FIXED: assert property (@(posedge clk) disable iff (rst)
      (xferEnd && !blockMode && !ctrlB_reg[B_STEP_EN] && !wrEn) |=> $stable(dest_reg))
      else $error("destination moved while stepping disabled");
   AST_DEST_STEP: assert property (@(posedge clk) disable iff (rst)
      (xferEnd && !blockMode && ctrlB_reg[B_STEP_EN] && !ctrlB_reg[B_DIR] && !wrEn)
      |=> dest_reg == $past(dest_reg) + (ctrlA_reg[A_SIZE] ? 24'h000002 : 24'h000001))
      else $error("destination step size wrong");
   AST_BURST_HOLD: assert property (@(posedge clk) disable iff (rst)
      (xferEnd && burst && chanOn && !higherMasterReq && count_reg > 16'h0001)
      |=> busReq_reg && start_reg)
      else $error("burst released the bus early");
   AST_STEAL_RELEASE: assert property (@(posedge clk) disable iff (rst)
      (xferEnd && !burst && !blockMode) |=> !busReq_reg ##1 !busReq_reg)
      else $error("cycle steal kept the bus");
   AST_BLOCK_RESTORE: assert property (@(posedge clk) disable iff (rst)
      (blockEnd && !ctrlB_reg[B_BLK_SIDE] && !wrEn) |=> dest_reg == destInit_reg)
      else $error("block side address not restored");
   AST_FULL_ONLY: assert property (@(posedge clk) disable iff (rst)
      (state_reg == ST_IDLE && !fullMode) |=> !busReq_reg)
      else $error("channel requested bus outside full address mode");

   COV_BURST: cover property (@(posedge clk) disable iff (rst) xferEnd && burst ##1 start_reg);
   COV_NMI_SUSPEND: cover property (@(posedge clk) disable iff (rst)
      nmi && ctrlB_reg[B_MTE] && pend_reg);
   COV_BLOCK_END: cover property (@(posedge clk) disable iff (rst) blockEnd);
   COV_EXT_EDGE: cover property (@(posedge clk) disable iff (rst) edgeEv ##[1:20] xferEnd);
endmodule // dma_full_address_channel_control

/* design/dma_fa_pkg.sv */
package dma_fa_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]  OFF_CTRL_A  = 8'h00;
   localparam logic [7:0]  OFF_CTRL_B  = 8'h04;
   localparam logic [7:0]  OFF_DEST    = 8'h08;
   localparam logic [7:0]  OFF_SRC     = 8'h0C;
   localparam logic [7:0]  OFF_COUNT   = 8'h10;
   localparam logic [7:0]  OFF_BLOCK   = 8'h14;
   localparam logic [7:0]  OFF_STATUS  = 8'h18;
   localparam logic [7:0]  OFF_MASK    = 8'h1C;
   localparam logic [7:0]  OFF_STATE   = 8'h20;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [23:0] ADDR_RESET  = 24'h000000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0]  BLK_RESET   = 8'h00;
   localparam logic [1:0]  EVT_RESET   = 2'h0;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int A_TE        = 7;
   localparam int A_SIZE      = 6;
   localparam int A_SDIR      = 5;
   localparam int A_SSTEP     = 4;
   localparam int A_FULL_HI   = 2;
   localparam int A_FULL_LO   = 1;
   localparam int A_BLOCK     = 0;
   localparam int B_MTE       = 7;
   localparam int B_RSVD      = 6;
   localparam int B_DIR       = 5;
   localparam int B_STEP_EN   = 4;
   localparam int B_BLK_SIDE  = 3;
   localparam int EV_DONE     = 0;
   localparam int EV_NMI      = 1;

   // ---------------------------------------------------------------
   // activation codes and steps
   // ---------------------------------------------------------------
   localparam logic [2:0]  ACT_BURST    = 3'h0;
   localparam logic [2:0]  ACT_STEAL    = 3'h2;
   localparam logic [2:0]  ACT_EXT_FALL = 3'h6;
   localparam logic [2:0]  ACT_EXT_LOW  = 3'h7;
   localparam logic [23:0] STEP_BYTE    = 24'h000001;
   localparam logic [23:0] STEP_WORD    = 24'h000002;
   localparam logic [15:0] COUNT_ONE    = 16'h0001;
   localparam logic [7:0]  BLK_ONE      = 8'h01;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REQ  = 2'b01,
      ST_XFER = 2'b10,
      ST_GAP  = 2'b11
   } eng_state_t;
endpackage

/* design/act_if.sv */
`timescale 1ns/10ps
interface act_if;
   logic extLow;
   logic extFall;
   modport drive (output extLow, output extFall);
   modport sink  (input extLow, input extFall);
endinterface

/* design/req_sync.sv */
`timescale 1ns/10ps
module req_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pin
   input  wire logic extReqPin,
   // conditioned request
   act_if.drive      act
);
   logic s1_reg, s1_next;
   logic s2_reg, s2_next;
   logic s3_reg, s3_next;

   // ----------------------------------------
   // two-flop synchroniser, then history
   // ----------------------------------------
   always_comb begin
      s1_next = extReqPin;
      s2_next = s1_reg;
      s3_next = s2_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end

   assign act.extLow  = ~s2_reg;
   assign act.extFall = s3_reg & ~s2_reg;

   AST_FALL_SYNCED: assert property (@(posedge clk) disable iff (rst)
      act.extFall |-> $past(s2_reg) && !s2_reg)
      else $error("falling edge not from synchronised level");
endmodule // req_sync

/* dv/bus_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// system bus stand-in: grants the engine, ends each transfer
// ------------------------------------------------
module bus_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // engine side
   input  wire logic busRequest,
   input  wire logic xferStart,
   input  wire logic slow,
   output logic      busGrant,
   output logic      xferDone
);
   logic [2:0] pipeReg;
   // slow mode stretches each transfer so a suspension can land mid-run
   always_ff @(posedge clk) begin
      pipeReg  <= rst ? 3'h0 : {pipeReg[1:0], xferStart};
      busGrant <= !rst && busRequest;
      xferDone <= !rst && (slow ? pipeReg[2] : pipeReg[0]);
   end
endmodule // bus_model

/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import dma_fa_pkg::*;
   // ------------------------------------------------
   // stimulus and bookkeeping
   // ------------------------------------------------
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, nmi, standby, extReqPin;
   logic        busRequest, busGrant, xferStart, xferWord, xferDone, irq, slow, rdErr;
   logic        hcr, hmr, lastReq;
   logic [3:0]  tmr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] xferSrc, xferDst;
   int          errCount, checksDone, cycles, starts, s0, drops;

   dma_full_address_channel_control i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nmi(nmi), .standby(standby), .timerMatch(tmr),
      .extReqPin(extReqPin), .higherChannelReq(hcr), .busRequest(busRequest),
      .busGrant(busGrant), .higherMasterReq(hmr), .xferStart(xferStart),
      .xferSrc(xferSrc), .xferDst(xferDst), .xferWord(xferWord), .xferDone(xferDone),
      .irq(irq));
   bus_model i_bus (.clk(clk), .rst(rst), .busRequest(busRequest), .xferStart(xferStart),
      .slow(slow), .busGrant(busGrant), .xferDone(xferDone));

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   // limit sized well above the whole sequence
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (xferStart === 1'h1) starts <= starts + 1;
      // falling edges of the bus request, one per release
      lastReq <= busRequest;
      if (lastReq === 1'h1 && busRequest === 1'h0) drops <= drops + 1;
      if (cycles == 20000) begin
         errCount++;
         conclude();
      end
   end

   task conclude;
      if (errCount == 0 && checksDone > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checksDone++;
      if (s !== e) begin
         $display("FAIL %s expected %h seen %h", nm, e, s);
         errCount++;
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'h1;
      // pready, data and error are taken at the edge that sees pready high
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      rdErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      chk("pready", 32'h1, {31'h0, n < 20});
   endtask

   // the master enable bit only takes after a read of the register
   task setReg(input logic [7:0] a, input logic [31:0] d);
      apb(1'h0, a, 32'h0);
      apb(1'h1, a, d);
   endtask

   task prog(input logic [7:0] a, input logic [7:0] b, input logic [15:0] cnt);
      apb(1'h1, OFF_DEST, 32'h100);
      apb(1'h1, OFF_SRC, 32'h200);
      apb(1'h1, OFF_COUNT, {16'h0, cnt});
      setReg(OFF_CTRL_B, {24'h0, b});
      chk("idle bus", 32'h0, {31'h0, busRequest});
      setReg(OFF_CTRL_A, {24'h0, a});
   endtask

   task finish(input logic [23:0] exp);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq !== 1'h1 && n < 600);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'h0, OFF_DEST, 32'h0);
      chk("dest", {8'h0, exp}, rd);
      apb(1'h1, OFF_STATUS, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq clear", 32'h0, {31'h0, irq});
   endtask

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   // writes in a row carry no read, so the enable must not take
   task regTest;
      apb(1'h0, OFF_CTRL_B, 32'h0);
      chk("ctrl b reset", 32'h0, rd);
      apb(1'h1, OFF_CTRL_B, 32'h40);
      apb(1'h1, OFF_CTRL_B, 32'hC0);
      apb(1'h0, OFF_CTRL_B, 32'h0);
      chk("reserved bit", 32'h40, rd & 32'h40);
      chk("unarmed enable", 32'h0, rd & 32'h80);
      apb(1'h0, 8'h3C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, rdErr});
      apb(1'h1, OFF_MASK, 32'h1);
   endtask

   task autoTest;
      prog(8'h86, 8'h90, 16'h0003);
      finish(24'h000103);
      prog(8'hC6, 8'hB2, 16'h0002);
      finish(24'h0000FC);
      // a higher master breaks the burst after every transfer
      s0 = drops;
      hmr <= 1'h1;
      prog(8'h86, 8'hA0, 16'h0002);
      finish(24'h000100);
      chk("bus freed per transfer", 32'h2, drops - s0);
      hmr <= 1'h0;
   endtask

   task pinTest;
      s0 = starts;
      prog(8'h86, 8'h97, 16'h0001);
      repeat (20) @(posedge clk);
      chk("no pin request", 32'h0, starts - s0);
      extReqPin <= 1'h0;
      finish(24'h000101);
      extReqPin <= 1'h1;
      // an edge while the channel is off must be lost
      setReg(OFF_CTRL_B, 32'h96);
      extReqPin <= 1'h0;
      repeat (5) @(posedge clk);
      extReqPin <= 1'h1;
      s0 = starts;
      prog(8'h86, 8'h96, 16'h0001);
      repeat (20) @(posedge clk);
      chk("edge while off", 32'h0, starts - s0);
      extReqPin <= 1'h0;
      finish(24'h000101);
      extReqPin <= 1'h1;
   endtask

   // two blocks of two bytes, destination is the block area
   task blockTest;
      apb(1'h1, OFF_BLOCK, 32'h0202);
      s0 = starts;
      prog(8'h87, 8'h91, 16'h0002);
      hcr <= 1'h1;
      tmr <= 4'h1;
      @(posedge clk) tmr <= 4'h2;
      @(posedge clk) tmr <= 4'h0;
      repeat (20) @(posedge clk);
      chk("deferred by higher channel", 32'h0, starts - s0);
      hcr <= 1'h0;
      repeat (30) @(posedge clk);
      chk("one block per match", 32'h2, starts - s0);
      tmr <= 4'h2;
      @(posedge clk) tmr <= 4'h0;
      finish(24'h000100);
   endtask

   task standbyTest;
      setReg(OFF_CTRL_B, 32'hC0);
      standby <= 1'h1;
      @(posedge clk) standby <= 1'h0;
      apb(1'h0, OFF_CTRL_B, 32'h0);
      chk("standby clear", 32'h0, rd);
   endtask

   // suspend a long burst, then resume it
   task suspendTest;
      slow <= 1'h1;
      s0 = starts;
      prog(8'h86, 8'h90, 16'h0006);
      repeat (8) @(posedge clk);
      nmi <= 1'h1;
      @(posedge clk) nmi <= 1'h0;
      repeat (10) @(negedge clk);
      chk("bus freed", 32'h0, {31'h0, busRequest});
      apb(1'h0, OFF_CTRL_B, 32'h0);
      chk("master cleared", 32'h10, rd);
      apb(1'h1, OFF_CTRL_B, 32'h90);
      finish(24'h000106);
      chk("total transfers", 32'h6, starts - s0);
      slow <= 1'h0;
   endtask

   initial begin
      {psel, penable, pwrite, nmi, standby, slow, rdErr, hcr, hmr, lastReq} = 10'h0;
      {paddr, pwdata, rd} = 72'h0;
      {errCount, checksDone, cycles, starts, s0, drops} = '0;
      tmr = 4'h0;
      extReqPin = 1'h1;
      rst = 1'h1;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      regTest();
      autoTest();
      suspendTest();
      pinTest();
      blockTest();
      standbyTest();
      conclude();
   end
endmodule // tb_top
